// [rao_open_checker.sv]
/*
  Open-command parameter checker: applies defaults, checks buffers, RAM
  window, list sizes and LLC resources, reads the host ident block,
  runs the insertion timer, then builds the completion word.
  Assumes the host memory port answers reads with a one-cycle pulse and
  that the ring insertion engine reports phase results on its own ports.
*/
// Notes on behaviour
// R1: data ram start must lie 1000..BFFE
// R2: host aligns start two below eight-byte
// R3: ram parity fault raises adapter check
// R4: host gives even ram end address
// R5: minimum buffers reserved for transmit only
// R6: zero transmit maximum means six buffers
// R7: largest frame is txmax times size-8
// R8: read eighteen ident bytes, 24-bit pointer
// R9: zero access point limit means two
// R10: zero station limit means six
// R11: host keeps group limits within sap limit
// R12: zero timer inputs select listed defaults
// R13: host gives frame size at least 15
// R14: write status block, then status interrupt
// R15: success sets bit 0 alone
// R16: bit 1 for bad node address
// R17: bit 2 for bad list size
// R18: bit 3 for bad buffer size/count
// R19: bit 4 for ram window or fault
// R20: bit 5 for under two receive buffers
// R21: bit 6 plus phase nibble on insertion
// R22: insertion error code in bits 12-15
// R23: 18-second insertion timer gives timeout
// R24: bit 7 plus llc code bits 8-15
// R25: zero buffer size means 112 bytes
// R26: defaults applied before checks
// R27: all applicable error bits reported together
module rao_open_checker
  import rao_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire rao_parms_t  parms_i,
  input  wire logic        node_addr_bad_i,
  input  wire logic [15:0] ram_words_i,
  input  wire logic        ram_test_done_i,
  input  wire logic        ram_fault_i,
  input  wire logic        ram_parity_i,
  input  wire logic        mem_rvalid_i,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        ins_done_i,
  input  wire logic        ins_fail_i,
  input  wire logic [3:0]  ins_phase_i,
  input  wire logic [3:0]  ins_code_i,
  output logic             ram_test_go_o,
  output logic             mem_rd_o,
  output logic [23:0]      mem_addr_o,
  output logic             ins_go_o,
  output logic             busy_o,
  output logic             status_block_we_o,
  output logic [15:0]      status_block_cmd_word_o,
  output logic [15:0]      status_block_word0_o,
  output logic             cmd_status_irq_o,
  output logic             adapter_check_o,
  output logic             attach_ok_flag_o,
  output logic [7:0]       txbuf_reserved_o,
  output logic [7:0]       txbuf_limit_o,
  output logic [15:0]      buf_size_o,
  output logic [15:0]      max_tx_frame_o,
  output logic [7:0]       access_point_limit_o,
  output logic [7:0]       station_limit_o,
  output rao_timers_t      timers_o,
  output logic [143:0]     host_ident_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_RAMTEST, ST_IDENT, ST_INSERT, ST_DONE
  } rao_state_t;

  rao_state_t  state_q;
  rao_parms_t  p_q;
  logic [15:0] err_q;
  logic [4:0]  ident_cnt_q;
  logic        rd_pend_q;
  logic [31:0] tick_cnt_q;
  logic [15:0] ins_ticks_q;

  ////////////////////////////////////////////////////////////////////////
  // effective values: defaults substituted before any check
  logic [15:0] bsz_eff;
  logic [7:0]  txmax_eff;
  logic [7:0]  sap_eff;
  logic [7:0]  stn_eff;
  logic [15:0] ram_bytes;
  logic [15:0] buf_total;
  logic [7:0]  buf_total8;
  logic [15:0] llc_bytes;
  logic [15:0] llc_bufs;
  logic [7:0]  sap_cap;
  logic [15:0] rx_left;
  rao_timers_t tmr_eff;

  always_comb begin
    bsz_eff   = (p_q.buf_size == 16'h0000) ? BUF_SIZE_DEF
                : p_q.buf_size; // R25 R26
    txmax_eff = (p_q.txbuf_max == 8'h00) ? TXMAX_DEF : p_q.txbuf_max; // R6 R26
    sap_eff   = (p_q.access_point_limit == 8'h00) ? SAP_DEF
                : p_q.access_point_limit; // R9
    stn_eff   = (p_q.station_limit == 8'h00) ? STATION_DEF
                : p_q.station_limit; // R10
    ram_bytes = (p_q.ram_end > p_q.ram_start)
                ? 16'(p_q.ram_end - p_q.ram_start) : 16'h0000;
    buf_total = (bsz_eff == 16'h0000) ? 16'h0000 : 16'(ram_bytes / bsz_eff);
    buf_total8 = (buf_total > 16'h00FF) ? 8'hFF : buf_total[7:0];
    // llc control blocks eat buffers out of the receive pool
    llc_bytes = 16'(32'(sap_eff) * LLC_BYTES_SAP
                + 32'(stn_eff) * LLC_BYTES_STN);
    llc_bufs  = p_q.llc_enable ? 16'((32'(llc_bytes) + 32'(bsz_eff) - 1)
                / ((bsz_eff == 16'h0000) ? 32'd1 : 32'(bsz_eff)))
                : 16'h0000;
    rx_left   = (buf_total > 16'(txmax_eff) + llc_bufs)
                ? 16'(buf_total - 16'(txmax_eff) - llc_bufs) : 16'h0000;
    // sap limit trimmed to what ram leaves for llc use
    sap_cap   = (buf_total8 > 8'h08) ? 8'(buf_total8 >> 1) : 8'h02;
    tmr_eff.t1_short = (p_q.t1_short == 8'h00) ? T1S_DEF : p_q.t1_short; // R12
    tmr_eff.t2_short = (p_q.t2_short == 8'h00) ? T2S_DEF : p_q.t2_short; // R12
    tmr_eff.idle_short = (p_q.idle_short == 8'h00) ? TIS_DEF
                         : p_q.idle_short; // R12
    tmr_eff.t1_long  = (p_q.t1_long == 8'h00) ? T1L_DEF : p_q.t1_long; // R12
    tmr_eff.t2_long  = (p_q.t2_long == 8'h00) ? T2L_DEF : p_q.t2_long; // R12
    tmr_eff.idle_long  = (p_q.idle_long == 8'h00) ? TIL_DEF
                         : p_q.idle_long; // R12
  end

  function automatic logic list_ok(input logic [15:0] v);
    list_ok = (v == 16'h0000) || (v == LIST_SZ_A) ||
              (v == LIST_SZ_B) || (v == LIST_SZ_C);
  endfunction

  // every static check at once so all faults show together
  logic [15:0] static_err;
  always_comb begin
    static_err = 16'h0000;
    static_err[CW_NODE_BIT] = node_addr_bad_i; // R16
    static_err[CW_LIST_BIT] = !list_ok(p_q.rx_list_size) ||
                              !list_ok(p_q.tx_list_size); // R17
    static_err[CW_BUF_BIT]  = (bsz_eff < BUF_SIZE_MIN) ||
                              (bsz_eff[2:0] != 3'h0) ||
                              (buf_total < 16'(RX_BUF_MIN)); // R18
    static_err[CW_RAM_BIT]  = (p_q.ram_start < RAM_LOW) ||
                              (p_q.ram_start > RAM_START_MAX) ||
                              (p_q.ram_end > RAM_HIGH) ||
                              (p_q.ram_end < RAM_LOW); // R1 R19
    static_err[CW_TXB_BIT]  = (buf_total <
                               16'(txmax_eff) + 16'(RX_BUF_MIN)); // R20
    if (p_q.llc_enable && p_q.bad_llc_opts) begin
      static_err[CW_LLC_BIT] = 1'b1; // R24
      static_err[15:8] = LLC_BAD_OPTS;
    end else if (p_q.llc_enable && rx_left < 16'(RX_BUF_MIN)) begin
      static_err[CW_LLC_BIT] = 1'b1; // R24
      static_err[15:8] = LLC_NO_RXBUF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE:    if (start_i) state_q <= ST_CHECK;
        ST_CHECK:   state_q <= ST_RAMTEST;
        ST_RAMTEST: begin
          if (ram_test_done_i && ram_parity_i) state_q <= ST_IDLE; // R3
          else if (ram_test_done_i) state_q <= ST_IDENT;
        end
        ST_IDENT: begin
          if (ident_cnt_q == IDENT_BYTES) begin
            state_q <= (err_q != 16'h0000) ? ST_DONE : ST_INSERT;
          end
        end
        ST_INSERT: begin
          if (ins_done_i || ins_fail_i ||
              ins_ticks_q >= 16'(INSERT_TICKS)) state_q <= ST_DONE;
        end
        ST_DONE:    state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      p_q <= '0;
    end else if (ce_i && state_q == ST_IDLE && start_i) begin
      p_q <= parms_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion word accumulation
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_q <= 16'h0000;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE:    if (start_i) err_q <= 16'h0000;
        ST_CHECK:   err_q <= static_err; // R27
        ST_RAMTEST: if (ram_test_done_i && ram_fault_i && !ram_parity_i)
                      err_q[CW_RAM_BIT] <= 1'b1; // R19
        ST_INSERT: begin
          if (ins_fail_i) begin
            err_q[CW_INS_BIT] <= 1'b1; // R21
            err_q[CW_PHASE_LSB +: 4] <= ins_phase_i; // R21
            err_q[CW_CODE_LSB +: 4] <= ins_code_i; // R22
          end else if (!ins_done_i &&
                       ins_ticks_q >= 16'(INSERT_TICKS)) begin
            err_q[CW_INS_BIT] <= 1'b1; // R23
            err_q[CW_PHASE_LSB +: 4] <= ins_phase_i;
            err_q[CW_CODE_LSB +: 4] <= ERR_TIMEOUT; // R23
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one insertion timer spans every phase, counted in llc ticks
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q  <= '0;
      ins_ticks_q <= 16'h0000;
    end else if (ce_i) begin
      if (state_q != ST_INSERT) begin
        tick_cnt_q  <= '0;
        ins_ticks_q <= 16'h0000;
      end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
        tick_cnt_q  <= '0;
        ins_ticks_q <= 16'(ins_ticks_q + 16'h0001); // R23
      end else begin
        tick_cnt_q <= 32'(tick_cnt_q + 32'd1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host ident block fetch, top pointer byte dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ident_cnt_q  <= 5'h00;
      rd_pend_q    <= 1'b0;
      mem_rd_o     <= 1'b0;
      mem_addr_o   <= 24'h000000;
      host_ident_o <= '0;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      if (state_q != ST_IDENT) begin
        ident_cnt_q <= 5'h00;
        rd_pend_q   <= 1'b0;
      end else if (!rd_pend_q && ident_cnt_q != IDENT_BYTES) begin
        mem_rd_o   <= 1'b1;
        mem_addr_o <= 24'(p_q.host_ident_pointer[23:0]
                      + 24'(ident_cnt_q)); // R8
        rd_pend_q  <= 1'b1;
      end else if (rd_pend_q && mem_rvalid_i) begin
        host_ident_o <= {host_ident_o[135:0], mem_rdata_i}; // R8
        ident_cnt_q  <= 5'(ident_cnt_q + 5'h01);
        rd_pend_q    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status block write and effective configuration
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_block_we_o       <= 1'b0;
      status_block_cmd_word_o <= 16'h0000;
      status_block_word0_o    <= 16'h0000;
      cmd_status_irq_o        <= 1'b0;
      attach_ok_flag_o        <= 1'b0;
    end else if (ce_i) begin
      status_block_we_o <= 1'b0;
      cmd_status_irq_o  <= status_block_we_o; // R14
      if (state_q == ST_DONE) begin
        status_block_we_o       <= 1'b1; // R14
        status_block_cmd_word_o <= OPEN_CMD_CODE; // R14
        if (err_q == 16'h0000) begin
          status_block_word0_o <= 16'h0001 << CW_OK_BIT; // R15
          attach_ok_flag_o     <= 1'b1;
        end else begin
          status_block_word0_o <= err_q; // R27
          attach_ok_flag_o     <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      adapter_check_o <= 1'b0;
      ram_test_go_o   <= 1'b0;
      ins_go_o        <= 1'b0;
      busy_o          <= 1'b0;
    end else if (ce_i) begin
      adapter_check_o <= (state_q == ST_RAMTEST) && ram_test_done_i
                         && ram_parity_i; // R3
      ram_test_go_o   <= (state_q == ST_CHECK);
      ins_go_o        <= (state_q == ST_INSERT) && !ins_done_i
                         && !ins_fail_i;
      busy_o          <= (state_q != ST_IDLE) || start_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      txbuf_reserved_o     <= 8'h00;
      txbuf_limit_o        <= 8'h00;
      buf_size_o           <= 16'h0000;
      max_tx_frame_o       <= 16'h0000;
      access_point_limit_o <= 8'h00;
      station_limit_o      <= 8'h00;
      timers_o             <= '0;
    end else if (ce_i && state_q == ST_CHECK) begin
      txbuf_reserved_o     <= p_q.txbuf_min; // R5
      txbuf_limit_o        <= txmax_eff; // R6
      buf_size_o           <= bsz_eff; // R25
      max_tx_frame_o       <= 16'(32'(txmax_eff)
                              * 32'(bsz_eff - BUF_OVERHEAD)); // R7
      access_point_limit_o <= (sap_eff > sap_cap) ? sap_cap : sap_eff; // R9
      station_limit_o      <= stn_eff; // R10
      timers_o             <= tmr_eff; // R12
    end
  end

  // ram_words_i kept for sizing checks in ram-test engine variants
  logic unused_ram_words;
  assign unused_ram_words = ^ram_words_i;

endmodule // rao_open_checker

// [rao_pkg.sv]
/*
  Package for the ring adapter open-parameter checker: constants,
  defaults, completion-word layout and the parameter carrier struct.
  Assumes a single 25 MHz clock domain.
*/
package rao_pkg;

  // completion word bit positions
  localparam int unsigned CW_OK_BIT    = 0;
  localparam int unsigned CW_NODE_BIT  = 1;
  localparam int unsigned CW_LIST_BIT  = 2;
  localparam int unsigned CW_BUF_BIT   = 3;
  localparam int unsigned CW_RAM_BIT   = 4;
  localparam int unsigned CW_TXB_BIT   = 5;
  localparam int unsigned CW_INS_BIT   = 6;
  localparam int unsigned CW_LLC_BIT   = 7;
  localparam int unsigned CW_PHASE_LSB = 8;
  localparam int unsigned CW_CODE_LSB  = 12;

  localparam logic [15:0] OPEN_CMD_CODE  = 16'h0003;
  localparam logic [15:0] RAM_LOW        = 16'h1000;
  localparam logic [15:0] RAM_HIGH       = 16'hC000;
  localparam logic [15:0] RAM_START_MAX  = 16'hBFFE;
  localparam logic [15:0] BUF_SIZE_MIN   = 16'h0060;
  localparam logic [15:0] BUF_SIZE_DEF   = 16'h0070;
  localparam logic [15:0] BUF_OVERHEAD   = 16'h0008;
  localparam logic [15:0] LIST_SZ_A      = 16'h000E;
  localparam logic [15:0] LIST_SZ_B      = 16'h0014;
  localparam logic [15:0] LIST_SZ_C      = 16'h001A;
  localparam logic [7:0]  TXMAX_DEF      = 8'h06;
  localparam logic [7:0]  RX_BUF_MIN     = 8'h02;
  localparam logic [7:0]  SAP_DEF        = 8'h02;
  localparam logic [7:0]  STATION_DEF    = 8'h06;
  localparam logic [7:0]  T1S_DEF        = 8'h05;
  localparam logic [7:0]  T2S_DEF        = 8'h01;
  localparam logic [7:0]  TIS_DEF        = 8'h19;
  localparam logic [7:0]  T1L_DEF        = 8'h19;
  localparam logic [7:0]  T2L_DEF        = 8'h0A;
  localparam logic [7:0]  TIL_DEF        = 8'h7D;
  localparam logic [7:0]  LLC_BAD_OPTS   = 8'h06;
  localparam logic [7:0]  LLC_NO_RXBUF   = 8'h30;
  localparam logic [4:0]  IDENT_BYTES    = 5'h12;
  localparam int unsigned LLC_BYTES_SAP  = 64;
  localparam int unsigned LLC_BYTES_STN  = 128;

  // llc timer tick and insertion timer
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TICK_MS        = 40;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned INSERT_S       = 18;
  localparam int unsigned INSERT_TICKS   = INSERT_S * 1000 / TICK_MS;

  localparam logic [3:0] ERR_TIMEOUT     = 4'h5;

  typedef struct packed {
    logic [15:0] ram_start;
    logic [15:0] ram_end;
    logic [7:0]  txbuf_min;
    logic [7:0]  txbuf_max;
    logic [31:0] host_ident_pointer;
    logic [7:0]  access_point_limit;
    logic [7:0]  station_limit;
    logic [7:0]  group_point_limit;
    logic [7:0]  group_member_limit;
    logic [7:0]  t1_short;
    logic [7:0]  t2_short;
    logic [7:0]  idle_short;
    logic [7:0]  t1_long;
    logic [7:0]  t2_long;
    logic [7:0]  idle_long;
    logic [15:0] max_frame;
    logic [15:0] rx_list_size;
    logic [15:0] tx_list_size;
    logic [15:0] buf_size;
    logic        llc_enable;
    logic        bad_llc_opts;
  } rao_parms_t;

  typedef struct packed {
    logic [7:0] t1_short;
    logic [7:0] t2_short;
    logic [7:0] idle_short;
    logic [7:0] t1_long;
    logic [7:0] t2_long;
    logic [7:0] idle_long;
  } rao_timers_t;

endpackage

// [rao_open_checker_assertions.sv]
/*
  Concurrent checks on the open checker's ports: status posting,
  completion word, ident fetch addresses, parity abort, insertion fail.
  Assumes ce_i is held high by the bench and one clock domain.
*/
module rao_open_checker_assertions
  import rao_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        start_i,
  input wire rao_parms_t  parms_i,
  input wire logic        ram_test_done_i,
  input wire logic        ram_parity_i,
  input wire logic        ins_fail_i,
  input wire logic        ins_go_o,
  input wire logic        mem_rd_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic        busy_o,
  input wire logic        status_block_we_o,
  input wire logic [15:0] status_block_cmd_word_o,
  input wire logic [15:0] status_block_word0_o,
  input wire logic        cmd_status_irq_o,
  input wire logic        adapter_check_o,
  input wire logic        attach_ok_flag_o,
  input wire logic [7:0]  txbuf_limit_o,
  input wire logic [15:0] buf_size_o,
  input wire logic [15:0] max_tx_frame_o
);
  logic [23:0] base_q;
  logic [4:0]  n_q;

  // pointer top byte dropped on capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      base_q <= 24'h000000;
      n_q    <= 5'h00;
    end else if (ce_i && start_i && !busy_o) begin
      base_q <= parms_i.host_ident_pointer[23:0];
      n_q    <= 5'h00;
    end else if (mem_rd_o) begin
      n_q    <= n_q + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_post;
    ##1 (cmd_status_irq_o && status_block_cmd_word_o == OPEN_CMD_CODE);
  endsequence
  sequence s_fail_done;
    ##[1:6] (status_block_we_o && status_block_word0_o[CW_INS_BIT]);
  endsequence

  status_post_a: assert property (status_block_we_o |-> s_post)
    else $error("status interrupt missing after status write");
  ok_alone_a: assert property ((cmd_status_irq_o &&
    status_block_word0_o[CW_OK_BIT]) |-> status_block_word0_o == 16'h0001)
    else $error("success bit not alone");
  ok_flag_a: assert property (cmd_status_irq_o |->
    attach_ok_flag_o == status_block_word0_o[CW_OK_BIT])
    else $error("attach flag disagrees with word");
  frame_limit_a: assert property (attach_ok_flag_o &&
    cmd_status_irq_o |-> max_tx_frame_o ==
    16'(32'(txbuf_limit_o) * 32'(buf_size_o - BUF_OVERHEAD)))
    else $error("frame limit wrong");
  ident_addr_a: assert property (mem_rd_o |->
    mem_addr_o == base_q + 24'(n_q))
    else $error("ident read address wrong");
  ident_count_a: assert property (mem_rd_o |-> n_q < IDENT_BYTES)
    else $error("too many ident reads");
  parity_check_a: assert property ((busy_o && ram_test_done_i &&
    ram_parity_i) |-> ##[1:2] adapter_check_o)
    else $error("no adapter check on parity");
  parity_quiet_a: assert property (adapter_check_o |->
    (!status_block_we_o)[*6])
    else $error("status written after parity fault");
  ins_fail_a: assert property ((ins_go_o && ins_fail_i) |-> s_fail_done)
    else $error("insertion failure not reported");
endmodule // rao_open_checker_assertions

bind rao_open_checker rao_open_checker_assertions u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .start_i(start_i),
  .parms_i(parms_i), .ram_test_done_i(ram_test_done_i),
  .ram_parity_i(ram_parity_i), .ins_fail_i(ins_fail_i),
  .ins_go_o(ins_go_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
  .busy_o(busy_o), .status_block_we_o(status_block_we_o),
  .status_block_cmd_word_o(status_block_cmd_word_o),
  .status_block_word0_o(status_block_word0_o),
  .cmd_status_irq_o(cmd_status_irq_o), .adapter_check_o(adapter_check_o),
  .attach_ok_flag_o(attach_ok_flag_o), .txbuf_limit_o(txbuf_limit_o),
  .buf_size_o(buf_size_o), .max_tx_frame_o(max_tx_frame_o));

// [rao_host_mem.sv]
/*
  Host memory model: answers one byte read at a time, fast or slow.
  Assumes the reader waits for each answer before the next request.
*/
module rao_host_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rd_i,
  input  wire logic        slow_i,
  input  wire logic [23:0] addr_i,
  output logic             rvalid_o,
  output logic [7:0]       rdata_o
);
  logic       pend_q;
  logic [1:0] wait_q;
  logic [7:0] byte_q;

  // released bus toggles, so stale data never looks valid
  always_ff @(posedge clk_i) begin
    rvalid_o <= 1'h0;
    rdata_o  <= ~rdata_o;
    if (!rst_n_i) begin
      pend_q  <= 1'h0;
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      pend_q <= 1'h1;
      wait_q <= slow_i ? 2'h2 : 2'h0;
      byte_q <= addr_i[7:0] ^ 8'h5A;
    end else if (pend_q) begin
      if (wait_q == 2'h0) begin
        rvalid_o <= 1'h1;
        rdata_o  <= byte_q;
        pend_q   <= 1'h0;
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule // rao_host_mem

// [rao_open_checker_tb.sv]
/*
  Self-checking bench for the open checker: table of parameter cases,
  then defaults, ident fetch, insertion failures, llc, parity, reset.
  Assumes the host memory model and the bound assertion checker.
*/
module rao_open_checker_tb
  import rao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] rs, re, ls, bs;
    logic nb, fl;
    logic [15:0] ex;
  } rao_row_t;
  logic clk = 0, rst_n = 0, start = 0, node_bad = 0, done = 0, flt = 0;
  logic par = 0, ins_done = 0, ins_fail = 0, slow = 0, rvalid, ram_go;
  logic mem_rd, ins_go, busy, we, irq, achk, ok, ac_seen;
  logic flt_v = 0, par_v = 0, fail_v = 0;
  logic [3:0] ph = 0, cd = 0, ph_v = 0, cd_v = 0;
  logic [7:0] rdata, tres, tlim, apl, stl;
  logic [23:0] addr;
  logic [15:0] cmdw, w0, bsz, mfr, w_seen;
  logic [143:0] ident, exp_id;
  rao_parms_t parms = '0, base, p;
  rao_timers_t tim;
  rao_row_t rows [13];
  logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
  integer fail_count = 0, check_count = 0, cyc = 0;

  always #20 clk = ~clk;

  rao_open_checker u_rao_open_checker (.clk_i(clk), .rst_n_i(rst_n),
    .ce_i(1'h1), .start_i(start), .parms_i(parms),
    .node_addr_bad_i(node_bad), .ram_words_i(16'h0000),
    .ram_test_done_i(done), .ram_fault_i(flt), .ram_parity_i(par),
    .mem_rvalid_i(rvalid), .mem_rdata_i(rdata), .ins_done_i(ins_done),
    .ins_fail_i(ins_fail), .ins_phase_i(ph), .ins_code_i(cd),
    .ram_test_go_o(ram_go), .mem_rd_o(mem_rd), .mem_addr_o(addr),
    .ins_go_o(ins_go), .busy_o(busy), .status_block_we_o(we),
    .status_block_cmd_word_o(cmdw), .status_block_word0_o(w0),
    .cmd_status_irq_o(irq), .adapter_check_o(achk),
    .attach_ok_flag_o(ok), .txbuf_reserved_o(tres), .txbuf_limit_o(tlim),
    .buf_size_o(bsz), .max_tx_frame_o(mfr), .access_point_limit_o(apl),
    .station_limit_o(stl), .timers_o(tim), .host_ident_o(ident));
  rao_host_mem u_rao_host_mem (.clk_i(clk), .rst_n_i(rst_n), .rd_i(mem_rd),
    .slow_i(slow), .addr_i(addr), .rvalid_o(rvalid), .rdata_o(rdata));

  //////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input string nm, input logic [143:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // plays ram tester and insertion engine, returns the posted word
  task run_open(input rao_parms_t pp, input logic nb);
    logic sent;
    sent = 1'h0;
    w_seen = 16'hFFFF;
    ac_seen = 1'h0;
    @(posedge clk); start <= 1'h1; parms <= pp; node_bad <= nb;
    @(posedge clk); start <= 1'h0;
    repeat (3000) begin
      @(negedge clk);
      if (we === 1'h1) begin w_seen = w0; break; end
      if (achk === 1'h1) begin ac_seen = 1'h1; break; end
      if (ram_go === 1'h1) begin
        @(posedge clk); done <= 1'h1; flt <= flt_v; par <= par_v;
        @(posedge clk); done <= 1'h0; flt <= 1'h0; par <= 1'h0;
      end
      if (ins_go === 1'h1 && !sent) begin
        repeat (3) @(posedge clk);
        ins_done <= !fail_v; ins_fail <= fail_v; ph <= ph_v; cd <= cd_v;
        @(posedge clk); ins_done <= 1'h0; ins_fail <= 1'h0; sent = 1'h1;
      end
    end
    while (busy !== 1'h0) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin fail_count++; report_and_stop; end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    base = '0;
    base.ram_start = 16'h1FFE;
    base.ram_end = 16'hBFFE;
    base.txbuf_min = 8'h03;
    base.max_frame = 16'h0400;
    base.host_ident_pointer = 32'hAB12_3450; // top byte set, must be ignored
    rows = '{
      '{16'h1FFE, 16'hBFFE, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0001},
      '{16'h1FFE, 16'hBFFE, 16'h000E, 16'h0000, 1'h0, 1'h0, 16'h0001},
      '{16'h1FFE, 16'hBFFE, 16'h0014, 16'h0000, 1'h0, 1'h0, 16'h0001},
      '{16'h1FFE, 16'hBFFE, 16'h001A, 16'h0080, 1'h0, 1'h0, 16'h0001},
      '{16'h1FFE, 16'hBFFE, 16'h000F, 16'h0000, 1'h0, 1'h0, 16'h0004},
      '{16'h1FFE, 16'hBFFE, 16'h0000, 16'h0058, 1'h0, 1'h0, 16'h0008},
      '{16'h1FFE, 16'hBFFE, 16'h0000, 16'h0064, 1'h0, 1'h0, 16'h0008},
      '{16'h0FFE, 16'hBFFE, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0010},
      '{16'h1FFE, 16'h20DE, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0020},
      '{16'h1FFE, 16'h206E, 16'h0000, 16'h0000, 1'h0, 1'h0, 16'h0028},
      '{16'h1FFE, 16'hBFFE, 16'h0000, 16'h0000, 1'h1, 1'h0, 16'h0002},
      '{16'h1FFE, 16'hBFFE, 16'h0000, 16'h0000, 1'h0, 1'h1, 16'h0010},
      '{16'h1FFE, 16'hBFFE, 16'h000F, 16'h0058, 1'h0, 1'h0, 16'h000C}};
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      p = base;
      p.ram_start = rows[i].rs;
      p.ram_end = rows[i].re;
      p.rx_list_size = rows[i].ls;
      p.buf_size = rows[i].bs;
      flt_v = rows[i].fl;
      run_open(p, rows[i].nb);
      check("word0", w_seen, rows[i].ex);
    end
    flt_v = 1'h0;
    // clean open with every default in force
    run_open(base, 1'h0);
    check("cmd", cmdw, OPEN_CMD_CODE);
    check("txlim", tlim, 8'h06);
    check("bufsz", bsz, 16'h0070);
    check("frame", mfr, 16'h0270);
    check("saps", apl, 8'h02);
    check("stations", stl, 8'h06);
    check("timers", tim, 48'h05_01_19_19_0A_7D);
    check("reserved", tres, 8'h03);
    for (int k = 0; k < 18; k++) begin
      exp_id[143 - 8 * k -: 8] = 8'(8'h50 + k) ^ 8'h5A;
    end
    check("ident", ident, exp_id);
    // slow host and explicit values
    slow = 1'h1;
    p = base;
    p.txbuf_max = 8'h04;
    p.buf_size = 16'h0080;
    p.t1_short = 8'h09;
    run_open(p, 1'h0);
    slow = 1'h0;
    check("word0", w_seen, 16'h0001);
    check("ident", ident, exp_id);
    check("frame", mfr, 16'h01E0);
    check("t1s", tim.t1_short, 8'h09);
    // every insertion error code, phases in rotation
    fail_v = 1'h1;
    for (int k = 0; k < 8; k++) begin
      ph_v = 4'(k % 5 + 1);
      cd_v = codes[k];
      run_open(base, 1'h0);
      check("insfail", w_seen, {cd_v, ph_v, 8'h40});
    end
    fail_v = 1'h0;
    p = base;
    p.llc_enable = 1'h1;
    p.bad_llc_opts = 1'h1;
    run_open(p, 1'h0);
    check("llc", w_seen, 16'h0680);
    // fifteen buffers, llc blocks leave none for receive
    p.bad_llc_opts = 1'h0;
    p.ram_end = 16'h268E;
    p.access_point_limit = 8'h10;
    run_open(p, 1'h0);
    check("llcrx", w_seen, 16'h3080);
    check("sapcap", apl, 8'h07);
    // parity fault aborts without status
    par_v = 1'h1;
    run_open(base, 1'h0);
    par_v = 1'h0;
    check("achk", ac_seen, 1'h1);
    check("nostatus", w_seen, 16'hFFFF);
    // reset in mid-open, then a clean open again
    @(posedge clk); start <= 1'h1; parms <= base;
    @(posedge clk); start <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    check("rstbusy", busy, 1'h0);
    check("rstword", w0, 16'h0000);
    run_open(base, 1'h0);
    check("word0", w_seen, 16'h0001);
    report_and_stop;
  end
endmodule // rao_open_checker_tb
